// *** rtl/pdsc_defines.svh ***
// Purpose: named constants of the depth/stencil/clamp front end
// Assumes: colour lanes are signed Q2.14, 1.0 = 16'h4000
// Notes:   included by pdsc_top.sv only
`ifndef PDSC_DEFINES_SVH
`define PDSC_DEFINES_SVH
`define PDSC_FIFO_DEPTH 16
`define PDSC_X_LSB32    16'h0003
`define PDSC_X_LSB16    16'h0007
`define PDSC_Y_LSB      16'h0003
`define PDSC_ZERO       16'h0000
`define PDSC_ONE        16'h4000
`define PDSC_NEG_ONE    16'hC000
`define PDSC_S_MAX      16'h7FFF
`define PDSC_S_MIN      16'h8000
`endif

// *** rtl/pdsc_pkg.sv ***
// Purpose: types of the depth/stencil/clamp front end
// Assumes: nothing beyond the defines header
// Notes:   compare codes shared by stencil and depth
package pdsc_pkg;
  typedef enum logic [2:0] {
    PDSC_NEVER    = 3'h0,
    PDSC_LESS     = 3'h1,
    PDSC_EQUAL    = 3'h2,
    PDSC_LEQUAL   = 3'h3,
    PDSC_GREATER  = 3'h4,
    PDSC_NOTEQUAL = 3'h5,
    PDSC_GEQUAL   = 3'h6,
    PDSC_ALWAYS   = 3'h7
  } pdsc_cmp_e;
  typedef enum logic [1:0] {
    PDSC_RNG_UNORM = 2'h0,
    PDSC_RNG_SNORM = 2'h1,
    PDSC_RNG_RT    = 2'h2
  } pdsc_range_e;
  typedef enum logic [2:0] {
    PDSC_ST_IDLE  = 3'h1,
    PDSC_ST_FETCH = 3'h2,
    PDSC_ST_OUT   = 3'h4
  } pdsc_state_e;
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [23:0] z;
    logic        back;
    logic [63:0] color;
  } pdsc_pix_s;
endpackage

// *** rtl/pdsc_top.sv ***
// Purpose: depth coordinate, stencil/depth test and pre-blend clamp
// Assumes: config inputs steady while pixels are in flight
// Notes:   one pixel every three cycles at best; FIFO absorbs bursts
// Functional notes
// - legacy disable mode: add 2 (32bpp) or 3 (16bpp) origin X LSBs to depth X
// - legacy disable mode: add 2 origin Y LSBs to depth Y
// - colour coords always take full origin; depth only the low bits in legacy disable mode
// - newer scheme: depth coords are pixel coords plus signed 16-bit offsets
// - stored stencil is fetched before the stencil compare
// - back-face stencil set only when double-sided and back-facing
// - reference and stored stencil both masked, then compared by function
// - stencil never drops pixels; its outcome is forwarded
// - stencil disabled forwards pass
// - source depth clamped to viewport range before the stored read when depth enabled
// - depth compared by function, outcome forwarded, no discard
// - depth disabled forwards pass
// - blend off: clamp source when enabled, else pass through
// - integer targets ignore clamp settings and clamp to format range
// - blend on: clamp source, destination and constant when enabled
// - one shared clamp setting serves every render target write
`include "pdsc_defines.svh"
////////////////////////////////////////////////////////////////////////
module pdsc_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          rdy_q, rdy_d, empty_q, empty_d;
  logic          push, pop;
  always_comb begin
    push    = in_valid && rdy_q;
    pop     = out_ready && !empty_q;
    wp_d    = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d    = pop ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d   = (AW+1)'(cnt_q + push - pop);
    rdy_d   = cnt_d != (AW+1)'(D); // kept as a flop so in_ready leaves a register
    empty_d = cnt_d == '0;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_q    <= '0;
      rp_q    <= '0;
      cnt_q   <= '0;
      rdy_q   <= 1'b1;
      empty_q <= 1'b1;
    end else begin
      wp_q    <= wp_d;
      rp_q    <= rp_d;
      cnt_q   <= cnt_d;
      rdy_q   <= rdy_d;
      empty_q <= empty_d;
    end
  end
  // storage needs no reset; empty flag guards it
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
  assign in_ready  = rdy_q;
  assign out_valid = !empty_q;
  assign out_data  = mem_q[rp_q];
endmodule
////////////////////////////////////////////////////////////////////////
module pdsc_top (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [15:0] in_x,
  input  wire logic [15:0] in_y,
  input  wire logic [23:0] in_depth,
  input  wire logic        in_back,
  input  wire logic [63:0] in_color,
  input  wire logic        legacy_mode,
  input  wire logic        depth_origin_offset_disable,
  input  wire logic        color_32bpp,
  input  wire logic [15:0] origin_x,
  input  wire logic [15:0] origin_y,
  input  wire logic [15:0] depth_off_x,
  input  wire logic [15:0] depth_off_y,
  input  wire logic        stencil_en,
  input  wire logic        dbl_stencil_en,
  input  wire logic [7:0]  st_ref_f,
  input  wire logic [7:0]  st_mask_f,
  input  wire logic [2:0]  st_func_f,
  input  wire logic [7:0]  st_ref_b,
  input  wire logic [7:0]  st_mask_b,
  input  wire logic [2:0]  st_func_b,
  input  wire logic        depth_en,
  input  wire logic [2:0]  depth_func,
  input  wire logic [23:0] vp_min,
  input  wire logic [23:0] vp_max,
  input  wire logic        blend_en,
  input  wire logic        preclamp_en,
  input  wire logic [1:0]  clamp_range,
  input  wire logic        rt_int,
  input  wire logic        rt_sint,
  input  wire logic [63:0] const_color,
  output logic             fetch_req,
  output logic [15:0]      fetch_x,
  output logic [15:0]      fetch_y,
  input  wire logic        fetch_valid,
  input  wire logic [7:0]  fetch_stencil,
  input  wire logic [23:0] fetch_depth,
  input  wire logic [63:0] fetch_color,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [15:0]      out_cx,
  output logic [15:0]      out_cy,
  output logic [63:0]      out_src,
  output logic [63:0]      out_dst,
  output logic [63:0]      out_const,
  output logic             out_stencil_pass,
  output logic             out_depth_pass
);
  function automatic logic cmp(input logic [2:0] f, input logic [23:0] a, input logic [23:0] b);
    case (pdsc_pkg::pdsc_cmp_e'(f))
      pdsc_pkg::PDSC_NEVER:    cmp = 1'b0;
      pdsc_pkg::PDSC_LESS:     cmp = a < b;
      pdsc_pkg::PDSC_EQUAL:    cmp = a == b;
      pdsc_pkg::PDSC_LEQUAL:   cmp = a <= b;
      pdsc_pkg::PDSC_GREATER:  cmp = a > b;
      pdsc_pkg::PDSC_NOTEQUAL: cmp = a != b;
      pdsc_pkg::PDSC_GEQUAL:   cmp = a >= b;
      default:                 cmp = 1'b1;
    endcase
  endfunction
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    if ($signed(v) < $signed(lo)) begin
      clamp = lo;
    end else if ($signed(v) > $signed(hi)) begin
      clamp = hi;
    end else begin
      clamp = v;
    end
  endfunction
  ////////////////////////////////////////////////////////////////////
  localparam int PW = $bits(pdsc_pkg::pdsc_pix_s);
  pdsc_pkg::pdsc_pix_s f_pix;
  logic [PW-1:0]       f_data;
  logic                f_valid, f_pop;
  pdsc_fifo #(.W(PW), .D(`PDSC_FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   ({in_x, in_y, in_depth, in_back, in_color}),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );
  assign f_pix = pdsc_pkg::pdsc_pix_s'(f_data);
  ////////////////////////////////////////////////////////////////////
  // clamp range selection, one shared setting for all targets
  logic [15:0] lo, hi;
  logic        do_src, do_oth;
  logic [63:0] src_q, src_d, src_cl, dst_cl, cst_cl;
  always_comb begin
    do_src = rt_int || preclamp_en;
    do_oth = blend_en && preclamp_en && !rt_int;
    if (rt_int) begin
      lo = rt_sint ? `PDSC_S_MIN : `PDSC_ZERO;
      hi = `PDSC_S_MAX;
    end else if (clamp_range == pdsc_pkg::PDSC_RNG_UNORM) begin
      lo = `PDSC_ZERO;
      hi = `PDSC_ONE;
    end else if (clamp_range == pdsc_pkg::PDSC_RNG_SNORM) begin
      lo = `PDSC_NEG_ONE;
      hi = `PDSC_ONE;
    end else begin
      lo = `PDSC_S_MIN;
      hi = `PDSC_S_MAX;
    end
  end
  for (genvar c = 0; c < 4; c++) begin : g_lane
    assign src_cl[16*c +: 16] = do_src ? clamp(src_q[16*c +: 16], lo, hi) : src_q[16*c +: 16];
    assign dst_cl[16*c +: 16] = do_oth ? clamp(fetch_color[16*c +: 16], lo, hi) : fetch_color[16*c +: 16];
    assign cst_cl[16*c +: 16] = do_oth ? clamp(const_color[16*c +: 16], lo, hi) : const_color[16*c +: 16];
  end
  ////////////////////////////////////////////////////////////////////
  pdsc_pkg::pdsc_state_e st_q, st_d;
  logic [15:0] cx_q, cx_d, cy_q, cy_d, dx_q, dx_d, dy_q, dy_d;
  logic [23:0] dz_q, dz_d;
  logic        bk_q, bk_d, freq_q, freq_d, ov_q, ov_d, sp_q, sp_d, dp_q, dp_d;
  logic [63:0] osrc_q, osrc_d, odst_q, odst_d, ocst_q, ocst_d;
  logic [7:0]  s_ref, s_mask;
  logic [2:0]  s_func;
  logic [15:0] xlsb;
  always_comb begin
    st_d   = st_q;
    {cx_d, cy_d, dx_d, dy_d, dz_d, bk_d, src_d} = {cx_q, cy_q, dx_q, dy_q, dz_q, bk_q, src_q};
    freq_d = freq_q;
    ov_d   = ov_q;
    sp_d   = sp_q;
    dp_d   = dp_q;
    osrc_d = osrc_q;
    odst_d = odst_q;
    ocst_d = ocst_q;
    f_pop  = st_q == pdsc_pkg::PDSC_ST_IDLE;
    xlsb   = color_32bpp ? `PDSC_X_LSB32 : `PDSC_X_LSB16;
    // back set only for double-sided and back-facing
    s_ref  = (dbl_stencil_en && bk_q) ? st_ref_b : st_ref_f;
    s_mask = (dbl_stencil_en && bk_q) ? st_mask_b : st_mask_f;
    s_func = (dbl_stencil_en && bk_q) ? st_func_b : st_func_f;
    case (st_q)
      pdsc_pkg::PDSC_ST_IDLE: begin
        if (f_valid) begin
          cx_d = 16'(f_pix.x + origin_x);
          cy_d = 16'(f_pix.y + origin_y);
          if (legacy_mode && depth_origin_offset_disable) begin
            dx_d = 16'(f_pix.x + (origin_x & xlsb));
            dy_d = 16'(f_pix.y + (origin_y & `PDSC_Y_LSB));
          end else if (legacy_mode) begin
            dx_d = 16'(f_pix.x + origin_x);
            dy_d = 16'(f_pix.y + origin_y);
          end else begin
            dx_d = 16'(f_pix.x + depth_off_x);
            dy_d = 16'(f_pix.y + depth_off_y);
          end
          // clamp lands on the same edge that issues the fetch
          dz_d   = depth_en ? ((f_pix.z < vp_min) ? vp_min : (f_pix.z > vp_max) ? vp_max : f_pix.z) : f_pix.z;
          bk_d   = f_pix.back;
          src_d  = f_pix.color;
          freq_d = 1'b1;
          st_d   = pdsc_pkg::PDSC_ST_FETCH;
        end
      end
      pdsc_pkg::PDSC_ST_FETCH: begin
        if (fetch_valid) begin
          freq_d = 1'b0;
          sp_d   = !stencil_en || cmp(s_func, {16'h0000, s_ref & s_mask}, {16'h0000, fetch_stencil & s_mask});
          dp_d   = !depth_en || cmp(depth_func, dz_q, fetch_depth);
          osrc_d = src_cl;
          odst_d = dst_cl;
          ocst_d = cst_cl;
          ov_d   = 1'b1;
          st_d   = pdsc_pkg::PDSC_ST_OUT;
        end
      end
      pdsc_pkg::PDSC_ST_OUT: begin
        if (out_ready) begin
          ov_d = 1'b0;
          st_d = pdsc_pkg::PDSC_ST_IDLE;
        end
      end
      default: begin
        st_d = pdsc_pkg::PDSC_ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q   <= pdsc_pkg::PDSC_ST_IDLE;
      {cx_q, cy_q, dx_q, dy_q, dz_q, bk_q, src_q, freq_q, ov_q} <= '0;
      {sp_q, dp_q, osrc_q, odst_q, ocst_q}                    <= '0;
    end else begin
      st_q   <= st_d;
      cx_q   <= cx_d;
      cy_q   <= cy_d;
      dx_q   <= dx_d;
      dy_q   <= dy_d;
      dz_q   <= dz_d;
      bk_q   <= bk_d;
      src_q  <= src_d;
      freq_q <= freq_d;
      ov_q   <= ov_d;
      sp_q   <= sp_d;
      dp_q   <= dp_d;
      osrc_q <= osrc_d;
      odst_q <= odst_d;
      ocst_q <= ocst_d;
    end
  end
  assign fetch_req        = freq_q;
  assign fetch_x          = dx_q;
  assign fetch_y          = dy_q;
  assign out_valid        = ov_q;
  assign out_cx           = cx_q;
  assign out_cy           = cy_q;
  assign out_src          = osrc_q;
  assign out_dst          = odst_q;
  assign out_const        = ocst_q;
  assign out_stencil_pass = sp_q;
  assign out_depth_pass   = dp_q;
  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic take;
  assign take = f_pop && f_valid;
  legacy_x_a: assert property (take && legacy_mode && depth_origin_offset_disable && color_32bpp |=>
    dx_q == 16'($past(f_pix.x) + ($past(origin_x) & `PDSC_X_LSB32))) else $error("legacy depth x wrong");
  legacy_y_a: assert property (take && legacy_mode && depth_origin_offset_disable |=>
    dy_q == 16'($past(f_pix.y) + ($past(origin_y) & `PDSC_Y_LSB))) else $error("legacy depth y wrong");
  color_coord_a: assert property (take |=> cx_q == 16'($past(f_pix.x) + $past(origin_x)))
    else $error("colour x lacks full origin");
  depth_off_a: assert property (take && !legacy_mode |=>
    dy_q == 16'($past(f_pix.y) + $past(depth_off_y))) else $error("depth y offset wrong");
  fetch_first_a: assert property ($rose(ov_q) |-> $past(freq_q && fetch_valid))
    else $error("result before fetch");
  no_drop_a: assert property (freq_q && fetch_valid |=> ov_q ##1 (ov_q || st_q == pdsc_pkg::PDSC_ST_IDLE))
    else $error("pixel dropped");
  stencil_off_a: assert property ($rose(ov_q) && $past(!stencil_en) |-> sp_q)
    else $error("stencil off not passing");
  depth_range_a: assert property (st_q == pdsc_pkg::PDSC_ST_FETCH && depth_en && vp_min <= vp_max |->
    dz_q >= vp_min && dz_q <= vp_max) else $error("depth outside viewport");
  depth_off_pass_a: assert property ($rose(ov_q) && $past(!depth_en) |-> dp_q)
    else $error("depth off not passing");
  src_clamp_a: assert property ($rose(ov_q) && $past(preclamp_en && !rt_int && clamp_range == 2'h0) |->
    !osrc_q[15] && osrc_q[15:0] <= `PDSC_ONE) else $error("source not clamped");
  out_hold_a: assert property (ov_q && !out_ready |=> ov_q && $stable(osrc_q) && $stable(sp_q))
    else $error("output changed while stalled");
  cv_back_c: cover property ($rose(ov_q) && dbl_stencil_en && bk_q);
  cv_stall_c: cover property (ov_q && !out_ready ##1 out_ready);
  cv_full_c: cover property (!in_ready && in_valid);
endmodule

// *** bench/pdsc_far_model.sv ***
// Purpose: far side, stored depth/stencil/colour and downstream sink
// Assumes: stored data is a fixed hash of the depth coordinates
// Notes:   fetch data flips every idle cycle so stale beats never match
module pdsc_far_model (
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic        fetch_req,
  input  wire logic [15:0] fetch_x,
  input  wire logic [15:0] fetch_y,
  output logic             fetch_valid,
  output logic [7:0]       fetch_stencil,
  output logic [23:0]      fetch_depth,
  output logic [63:0]      fetch_color,
  output logic             out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned wait_n = 0;
  initial begin
    fetch_valid = 1'b0;
    {fetch_stencil, fetch_depth, fetch_color} = '0;
    out_ready = 1'b0;
  end
  always @(negedge clk) begin
    if (fetch_req && wait_n == 0) begin
      // one beat per request, latency varies 0..3
      fetch_valid   <= 1'b1;
      fetch_stencil <= fetch_x[7:0] ^ fetch_y[7:0];
      fetch_depth   <= {fetch_y[7:0], fetch_x};
      fetch_color   <= {fetch_x, fetch_y, fetch_x, fetch_y};
      wait_n        <= $urandom % 4;
    end else begin
      fetch_valid <= 1'b0;
      {fetch_stencil, fetch_depth, fetch_color} <= ~{fetch_stencil, fetch_depth, fetch_color};
      if (fetch_req) begin
        wait_n <= wait_n - 1;
      end
    end
    out_ready <= !stall && ($urandom % 4 != 0);
  end
endmodule

// *** bench/test_pdsc_top.sv ***
// Purpose: self-checking bench for the depth/stencil/clamp front end
// Assumes: config changes only with the pipeline drained
// Notes:   stored values come from the far model's coordinate hash
module test_pdsc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, sys_rst, stall, in_valid, in_ready, in_back, legacy_mode, depth_origin_offset_disable;
  logic        color_32bpp, stencil_en, dbl_stencil_en, depth_en, blend_en, preclamp_en, rt_int, rt_sint;
  logic        fetch_req, fetch_valid, out_valid, out_ready, out_stencil_pass, out_depth_pass;
  logic [15:0] in_x, in_y, origin_x, origin_y, depth_off_x, depth_off_y, fetch_x, fetch_y, out_cx, out_cy;
  logic [23:0] in_depth, vp_min, vp_max, fetch_depth;
  logic [7:0]  st_ref_f, st_mask_f, st_ref_b, st_mask_b, fetch_stencil;
  logic [2:0]  st_func_f, st_func_b, depth_func;
  logic [1:0]  clamp_range;
  logic [63:0] in_color, const_color, fetch_color, out_src, out_dst, out_const;
  logic [225:0] expq[$];
  int          mismatches = 0, tests_run = 0, cyc = 0, acc;
  pdsc_top i_pdsc_top (.*);
  pdsc_far_model i_pdsc_far_model (.*);
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic cmp(input logic [2:0] f, input logic [23:0] a, input logic [23:0] b);
    logic [7:0] r;
    r = {1'b1, a >= b, a != b, a > b, a <= b, a == b, a < b, 1'b0};
    return r[f];
  endfunction
  function automatic logic [63:0] clc(input logic [63:0] c, input logic on, input logic [15:0] lo,
                                      input logic [15:0] hi);
    for (int i = 0; i < 4; i++)
      if (on && $signed(c[16*i+:16]) < $signed(lo)) c[16*i+:16] = lo;
      else if (on && $signed(c[16*i+:16]) > $signed(hi)) c[16*i+:16] = hi;
    return c;
  endfunction
  task automatic chk(input logic [225:0] g, input logic [225:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic new_cfg();
    {legacy_mode, depth_origin_offset_disable, color_32bpp, stencil_en, dbl_stencil_en, depth_en, preclamp_en,
     st_func_f, st_func_b, depth_func, st_ref_f, st_mask_f} = $urandom; // depth buffer always present
    {st_ref_b, st_mask_b, rt_sint, blend_en, rt_int} = 19'($urandom);
    if (rt_int) blend_en = 1'b0;
    if (!blend_en && 1'($urandom)) preclamp_en = 1'b1; // advice mostly kept, raw pass-through still seen
    origin_x = 16'($urandom % 1024);
    origin_y = 16'($urandom % 1024);
    depth_off_x = 16'($urandom % 512) - 16'h0100; // pixels start at 256, plain 2D target
    depth_off_y = 16'($urandom % 512) - 16'h0100;
    vp_min = 24'($urandom) >> 1;
    vp_max = vp_min + (24'($urandom) >> 1);
    clamp_range = 2'($urandom % 3);
    const_color = {$urandom, $urandom};
  endtask
  task automatic rnd_pix();
    in_x = 16'h0100 + 16'($urandom % 4096);
    in_y = 16'h0100 + 16'($urandom % 4096);
    in_depth = 24'($urandom);
    in_back = 1'($urandom);
    in_color = {$urandom, $urandom};
  endtask
  task automatic expect_pix();
    logic [15:0] dx, dy, cx, cy, lo, hi;
    logic [7:0]  st, m;
    logic [23:0] s, dp;
    logic        b, sp, zp, dcl;
    cx = in_x + origin_x;
    cy = in_y + origin_y;
    if (!legacy_mode) {dx, dy} = {in_x + depth_off_x, in_y + depth_off_y};
    else if (depth_origin_offset_disable)
      {dx, dy} = {in_x + (origin_x & (color_32bpp ? 16'h0003 : 16'h0007)), in_y + (origin_y & 16'h0003)};
    else {dx, dy} = {cx, cy};
    st = dx[7:0] ^ dy[7:0];
    dp = {dy[7:0], dx};
    b = dbl_stencil_en && in_back;
    m = b ? st_mask_b : st_mask_f;
    sp = !stencil_en || cmp(b ? st_func_b : st_func_f, {16'h0000, (b ? st_ref_b : st_ref_f) & m},
                            {16'h0000, st & m});
    s = in_depth < vp_min ? vp_min : (in_depth > vp_max ? vp_max : in_depth);
    zp = !depth_en || cmp(depth_func, s, dp);
    lo = rt_int ? (rt_sint ? 16'h8000 : 16'h0000) : (clamp_range == 2'h0 ? 16'h0000 :
         (clamp_range == 2'h1 ? 16'hC000 : 16'h8000));
    hi = (rt_int || clamp_range == 2'h2) ? 16'h7FFF : 16'h4000;
    dcl = blend_en && preclamp_en && !rt_int;
    expq.push_back({cx, cy, clc(in_color, rt_int || preclamp_en, lo, hi), clc({dx, dy, dx, dy}, dcl, lo, hi),
                    clc(const_color, dcl, lo, hi), sp, zp});
  endtask
  task automatic send(input int n, input int tries);
    logic ok;
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      in_valid = 1'b1;
      rnd_pix();
      ok = 1'b0;
      for (int w = 0; w < tries && !ok; w++) begin
        @(posedge clk);
        ok = (in_ready === 1'b1);
      end
      if (!ok) break;
      expect_pix();
      acc++;
    end
    @(negedge clk);
    in_valid = 1'b0;
  endtask
  task automatic drain();
    while (expq.size() != 0) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // every accepted beat checked in order; stalls come from the far model
  always @(posedge clk)
    if (!sys_rst && out_valid === 1'b1 && out_ready === 1'b1)
      chk({out_cx, out_cy, out_src, out_dst, out_const, out_stencil_pass, out_depth_pass},
          expq.size() != 0 ? expq.pop_front() : '1);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      $display("timeout at %0t", $time);
      summarize();
    end
  end
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    stall = 1'b0;
    in_valid = 1'b0;
    void'($urandom(32'h9D3BCBD5));
    rnd_pix();
    new_cfg();
    repeat (6) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    for (int t = 0; t < 30; t++) begin
      @(negedge clk);
      new_cfg();
      acc = 0;
      send(24, 400);
      chk(226'(acc), 226'h18);
      drain();
      $display("test %0d done, checks %0d", t, tests_run);
    end
    // fill with the sink stalled: FIFO plus one pixel held in the engine
    @(negedge clk);
    stall = 1'b1;
    acc = 0;
    send(40, 3);
    chk(226'(acc), 226'h11); // sixteen queued plus one held
    @(negedge clk);
    stall = 1'b0;
    drain();
    $display("fill test done, accepted %0d", acc);
    summarize();
  end
endmodule
